// ---- common/lr4_cfg.svh ----
`ifndef LR4_CFG_SVH
`define LR4_CFG_SVH
// register addresses
`define LR4_ADDR_CFG      16'h4071
`define LR4_ADDR_ON       16'h4072
`define LR4_ADDR_SLP      16'h4073
`define LR4_ADDR_STAT     16'h4078
`define LR4_ADDR_MASK     16'h4079
// reset values and implemented-bit masks
`define LR4_CFG_RST       16'h0200
`define LR4_ON_RST        16'h0000
`define LR4_SLP_RST       16'h0100
`define LR4_CFG_BITS      16'hdfc1
`define LR4_STATE_BITS    16'he11f
`define LR4_STAT_BITS     16'h0001
`define LR4_MASK_RST      16'h0000
// field positions
`define LR4_ACT           15:14
`define LR4_SRC           12:11
`define LR4_VPICK         10
`define LR4_HWMODE        9:8
`define LR4_FLT           7
`define LR4_SWI           6
`define LR4_LPV           0
`define LR4_SLOT          15:13
`define LR4_OPMODE        8
`define LR4_VCODE         4:0
`define LR4_UV_BIT        0
// field codes
`define LR4_ACT_SHUT      2'h1
`define LR4_ACT_RESET     2'h2
`define LR4_SRC_IN1       2'h1
`define LR4_SRC_IN2       2'h2
`define LR4_SRC_ANY       2'h3
`define LR4_HWM_OFF       2'h1
`define LR4_HWM_FOLLOW    2'h3
`define LR4_SLOT_HWEN1    3'h6
`define LR4_SLOT_HWEN2    3'h7
`define LR4_SLOT_LAST     3'h5
`define LR4_SYNC_W        5
`endif

// ---- common/lr4_pkg.sv ----
package lr4_pkg;
  typedef enum logic [1:0] {
    LR4_OFF,
    LR4_ON,
    LR4_SLEEP
  } lr4_state_t;
  typedef logic [4:0] lr4_vcode_t;
  typedef logic [15:0] lr4_word_t;
endpackage : lr4_pkg

// ---- common/lr4_pin_if.sv ----
`timescale 1ns/1ps
// pins from outside the clock domain, raw and after synchronising
interface lr4_pin_if;
  logic [4:0] raw;
  logic [4:0] synced;
  modport sync (input raw, output synced);
  modport core (output raw, input synced);
endinterface : lr4_pin_if

// ---- src/lr4_sync.sv ----
`timescale 1ns/1ps
`include "lr4_cfg.svh"
module lr4_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  lr4_pin_if.sync  pins
);
  import lr4_pkg::*;
  logic [`LR4_SYNC_W-1:0] stage_a;
  logic [`LR4_SYNC_W-1:0] stage_b;

  // stage_a feeds stage_b only
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage_a <= '0;
      stage_b <= '0;
    end else begin
      stage_a <= pins.raw;
      stage_b <= stage_a;
    end
  end

  assign pins.synced = stage_b;
endmodule : lr4_sync

// ---- src/lr4_ctrl.sv ----
// Operation
// R1 - undervoltage action: 00 ignore, 01 shut regulator, 10 device reset, 11 nothing
// R2 - every undervoltage error raises the interrupt status bit
// R3 - control source: 00 off, 01 input 1, 10 input 2, 11 either input
// R4 - under hardware control voltage comes from ON code or SLEEP code by pick bit
// R5 - hardware mode 00/10 low power, 01 off, 11 ON mode bit; resets 10
// R6 - disabled output is discharged unless the float bit is set
// R7 - low-power variant bit: 0 selects 50mA, 1 selects 20mA
// R8 - ON slot 000 never enables, 001..101 enable in timeslots 1..5
// R9 - ON slot 110/111 hand enable to hardware enable input 1/2
// R10 - ON state: ON mode bit 0 normal, 1 low power; resets 0
// R11 - five-bit ON voltage code drives the output in ON state
// R12 - SLEEP slot 001..101 disable in timeslots 5,4,3,2,1
// R13 - SLEEP slot 000/110/111 stay on, apply SLEEP settings in slot 5/3/1
// R14 - with hardware enable, codes 001..101 pick the slot for entering SLEEP
// R15 - SLEEP state: SLEEP mode bit 0 normal, 1 low power; resets 1
// R16 - SLEEP voltage code uses the ON mapping, resets to code 0
// R17 - switch bit: 0 regulating, 1 pass switch; resets 0
// R18 - all fields read back, reset to defaults, unused bits read zero
`timescale 1ns/1ps
`include "lr4_cfg.svh"
module lr4_ctrl (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [15:0]       reg_addr,
  input  wire lr4_pkg::lr4_word_t reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output lr4_pkg::lr4_word_t     reg_rdata,
  input  wire logic [4:0]        slot_pulse,
  input  wire logic              startup_active,
  input  wire logic              sleep_active,
  input  wire logic              hw_enable_1,
  input  wire logic              hw_enable_2,
  input  wire logic              hw_control_1,
  input  wire logic              hw_control_2,
  input  wire logic              uv_error,
  output logic                   reg_enable,
  output lr4_pkg::lr4_vcode_t    reg_voltage_code,
  output logic                   reg_low_power,
  output logic                   reg_lp_variant,
  output logic                   reg_pass_switch,
  output logic                   reg_discharge,
  output logic                   device_reset_req,
  output logic                   irq
);
  import lr4_pkg::*;

  lr4_word_t  regulator_config;
  lr4_word_t  regulator_on_state;
  lr4_word_t  regulator_sleep_state;
  lr4_word_t  irq_status;
  lr4_word_t  irq_mask;
  lr4_state_t state;
  logic       uv_prev;
  logic       uv_event;
  logic       hwc_on;
  logic       hw_owned;
  logic       hw_en_sel;
  logic [3:0] sleep_plan;
  logic       on_hit;
  logic       sleep_hit;
  logic       next_enable;
  lr4_vcode_t next_vcode;
  logic       next_low_power;

  lr4_pin_if pins ();

  assign pins.raw = {uv_error, hw_control_2, hw_control_1, hw_enable_2, hw_enable_1};

  lr4_sync u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .pins     (pins)
  );

  // fields
  logic [1:0] undervoltage_action;
  logic [1:0] hw_control_source;
  logic       hw_control_voltage_pick;
  logic [1:0] hw_control_op_mode;
  logic       output_float_when_off;
  logic       pass_switch_select;
  logic       low_power_variant;
  logic [2:0] on_timeslot;
  logic       on_op_mode;
  lr4_vcode_t on_voltage_code;
  logic [2:0] sleep_timeslot;
  logic       sleep_op_mode;
  lr4_vcode_t sleep_voltage_code;

  assign undervoltage_action     = regulator_config[`LR4_ACT];
  assign hw_control_source       = regulator_config[`LR4_SRC];
  assign hw_control_voltage_pick = regulator_config[`LR4_VPICK];
  assign hw_control_op_mode      = regulator_config[`LR4_HWMODE];
  assign output_float_when_off   = regulator_config[`LR4_FLT];
  assign pass_switch_select      = regulator_config[`LR4_SWI];
  assign low_power_variant       = regulator_config[`LR4_LPV];
  assign on_timeslot             = regulator_on_state[`LR4_SLOT];
  assign on_op_mode              = regulator_on_state[`LR4_OPMODE];
  assign on_voltage_code         = regulator_on_state[`LR4_VCODE];
  assign sleep_timeslot          = regulator_sleep_state[`LR4_SLOT];
  assign sleep_op_mode           = regulator_sleep_state[`LR4_OPMODE];
  assign sleep_voltage_code      = regulator_sleep_state[`LR4_VCODE];

  // true when the pulse for timeslot n (1..5) is present; slot 0 never hits
  function automatic logic slot_at(input logic [4:0] pulse, input logic [2:0] n);
    logic hit;
    hit = 1'b0;
    if (n != 3'h0 && n <= `LR4_SLOT_LAST) begin
      hit = pulse[n - 3'h1];
    end
    return hit;
  endfunction : slot_at

  // {disable, slot} for the sleep transition code
  function automatic logic [3:0] sleep_decode(input logic [2:0] code);
    logic [3:0] plan;
    case (code)
      3'h0:    plan = {1'b0, 3'h5}; // R13
      3'h1:    plan = {1'b1, 3'h5}; // R12
      3'h2:    plan = {1'b1, 3'h4};
      3'h3:    plan = {1'b1, 3'h3};
      3'h4:    plan = {1'b1, 3'h2};
      3'h5:    plan = {1'b1, 3'h1};
      3'h6:    plan = {1'b0, 3'h3}; // R13
      default: plan = {1'b0, 3'h1};
    endcase
    return plan;
  endfunction : sleep_decode

  // hardware control source
  always_comb begin
    case (hw_control_source) // R3
      `LR4_SRC_IN1: hwc_on = pins.synced[2];
      `LR4_SRC_IN2: hwc_on = pins.synced[3];
      `LR4_SRC_ANY: hwc_on = pins.synced[2] | pins.synced[3];
      default:      hwc_on = 1'b0;
    endcase
  end

  assign hw_owned   = (on_timeslot == `LR4_SLOT_HWEN1) || (on_timeslot == `LR4_SLOT_HWEN2); // R9
  assign hw_en_sel  = (on_timeslot == `LR4_SLOT_HWEN1) ? pins.synced[0] : pins.synced[1]; // R9
  assign sleep_plan = sleep_decode(sleep_timeslot);
  assign on_hit     = slot_at(slot_pulse, on_timeslot); // R8
  assign sleep_hit  = slot_at(slot_pulse, sleep_plan[2:0]);

  // rising edge of the synchronised undervoltage flag
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      uv_prev <= 1'b0;
    end else begin
      uv_prev <= pins.synced[4];
    end
  end

  assign uv_event = pins.synced[4] & ~uv_prev;

  // regulator state; undervoltage shutdown wins over any sequencer step
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= LR4_OFF;
    end else if (uv_event && undervoltage_action == `LR4_ACT_SHUT) begin
      state <= LR4_OFF; // R1
    end else if (startup_active) begin
      if (hw_owned) begin
        state <= LR4_ON; // R9
      end else if (on_hit) begin
        state <= LR4_ON; // R8
      end
    end else if (sleep_active && state != LR4_OFF && sleep_hit) begin
      // a hardware-enabled regulator only moves into SLEEP
      if (sleep_plan[3] && !hw_owned) begin
        state <= LR4_OFF; // R12
      end else begin
        state <= LR4_SLEEP; // R13 R14
      end
    end
  end

  // output selection
  always_comb begin
    next_enable    = 1'b0;
    next_vcode     = on_voltage_code; // R11
    next_low_power = 1'b0;
    if (state != LR4_OFF) begin
      next_enable = hw_owned ? hw_en_sel : 1'b1;
      if (hwc_on) begin
        next_vcode = hw_control_voltage_pick ? sleep_voltage_code : on_voltage_code; // R4
        case (hw_control_op_mode) // R5
          `LR4_HWM_OFF:    next_enable = 1'b0;
          `LR4_HWM_FOLLOW: next_low_power = on_op_mode;
          default:         next_low_power = 1'b1;
        endcase
      end else if (state == LR4_SLEEP) begin
        next_vcode     = sleep_voltage_code; // R16
        next_low_power = sleep_op_mode; // R15
      end else begin
        next_low_power = on_op_mode; // R10
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_enable       <= 1'b0;
      reg_voltage_code <= '0;
      reg_low_power    <= 1'b0;
      reg_lp_variant   <= 1'b0;
      reg_pass_switch  <= 1'b0;
      reg_discharge    <= 1'b1;
    end else begin
      reg_enable       <= next_enable;
      reg_voltage_code <= next_vcode;
      reg_low_power    <= next_low_power;
      reg_lp_variant   <= low_power_variant; // R7
      reg_pass_switch  <= pass_switch_select; // R17
      reg_discharge    <= ~next_enable & ~output_float_when_off; // R6
    end
  end

  // one-cycle request to the device reset logic
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      device_reset_req <= 1'b0;
    end else begin
      device_reset_req <= uv_event && undervoltage_action == `LR4_ACT_RESET; // R1
    end
  end

  // configuration writes; unused bits are never stored
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      regulator_config      <= `LR4_CFG_RST; // R18
      regulator_on_state    <= `LR4_ON_RST;
      regulator_sleep_state <= `LR4_SLP_RST;
      irq_mask              <= `LR4_MASK_RST;
    end else if (reg_wr) begin
      if (reg_addr == `LR4_ADDR_CFG) begin
        regulator_config <= reg_wdata & `LR4_CFG_BITS; // R18
      end else if (reg_addr == `LR4_ADDR_ON) begin
        regulator_on_state <= reg_wdata & `LR4_STATE_BITS;
      end else if (reg_addr == `LR4_ADDR_SLP) begin
        regulator_sleep_state <= reg_wdata & `LR4_STATE_BITS;
      end else if (reg_addr == `LR4_ADDR_MASK) begin
        irq_mask <= reg_wdata & `LR4_STAT_BITS;
      end
    end
  end

  // sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
    end else begin
      if (reg_wr && reg_addr == `LR4_ADDR_STAT) begin
        irq_status <= irq_status & ~(reg_wdata & `LR4_STAT_BITS);
      end
      if (uv_event) begin
        irq_status[`LR4_UV_BIT] <= 1'b1; // R2
      end
    end
  end

  assign irq = |(irq_status & ~irq_mask);

  // read data in the cycle after the strobe only; unmapped reads zero
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == `LR4_ADDR_CFG) begin
      reg_rdata <= regulator_config; // R18
    end else if (reg_addr == `LR4_ADDR_ON) begin
      reg_rdata <= regulator_on_state;
    end else if (reg_addr == `LR4_ADDR_SLP) begin
      reg_rdata <= regulator_sleep_state;
    end else if (reg_addr == `LR4_ADDR_STAT) begin
      reg_rdata <= irq_status;
    end else if (reg_addr == `LR4_ADDR_MASK) begin
      reg_rdata <= irq_mask;
    end else begin
      reg_rdata <= '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  a_uv_sets_status: assert property ( // R2
    uv_event |=> irq_status[`LR4_UV_BIT])
    else $error("undervoltage did not set status");

  a_uv_shuts_down: assert property ( // R1
    uv_event && undervoltage_action == `LR4_ACT_SHUT |=> state == LR4_OFF ##1 !reg_enable)
    else $error("shutdown action did not turn regulator off");

  a_reset_request: assert property ( // R1
    device_reset_req == $past(uv_event && undervoltage_action == `LR4_ACT_RESET))
    else $error("device reset request mismatch");

  a_hwc_mode_off: assert property ( // R5
    state != LR4_OFF && hwc_on && hw_control_op_mode == `LR4_HWM_OFF |=> !reg_enable)
    else $error("hardware off mode left regulator on");

  a_hwc_voltage_pick: assert property ( // R4
    state != LR4_OFF && hwc_on |=> reg_voltage_code == $past(hw_control_voltage_pick ?
                                   sleep_voltage_code : on_voltage_code))
    else $error("hardware voltage pick wrong");

  a_off_discharge: assert property ( // R6
    !reg_enable |-> reg_discharge == !$past(output_float_when_off))
    else $error("discharge does not follow float bit");

  a_on_slot_enable: assert property ( // R8
    startup_active && !hw_owned && on_hit && !uv_event |=> state == LR4_ON ##1 reg_enable)
    else $error("regulator not enabled in its slot");

  a_sleep_disable: assert property ( // R12
    sleep_active && !startup_active && state != LR4_OFF && sleep_hit && sleep_plan[3] && !hw_owned
    && !uv_event |=> state == LR4_OFF)
    else $error("sleep slot did not disable regulator");

  a_on_mode_normal: assert property ( // R10
    state == LR4_ON && !hwc_on |=> reg_low_power == $past(on_op_mode))
    else $error("ON mode bit not applied");

  a_sleep_mode_apply: assert property ( // R15
    state == LR4_SLEEP && !hwc_on |=> reg_low_power == $past(sleep_op_mode)
    && reg_voltage_code == $past(sleep_voltage_code))
    else $error("SLEEP settings not applied");

  a_read_config: assert property ( // R18
    reg_rd && reg_addr == `LR4_ADDR_CFG |=> reg_rdata == $past(regulator_config)
    ##1 (reg_rdata == '0 || $past(reg_rd)))
    else $error("config readback wrong");

  a_irq_level: assert property ( // R2
    uv_event && !irq_mask[`LR4_UV_BIT] && !(reg_wr && reg_addr == `LR4_ADDR_MASK) |=> irq)
    else $error("unmasked undervoltage without interrupt");
endmodule : lr4_ctrl

// ---- dv/lr4_seq_model.sv ----
`timescale 1ns/1ps
module lr4_seq_model (
  input  wire logic core_clk,
  input  wire logic run_start,
  input  wire logic run_sleep,
  output logic [4:0] slot_pulse,
  output logic       startup_active,
  output logic       sleep_active,
  output logic [2:0] last_slot
);
  int cnt;
  initial begin
    cnt = 0;
    slot_pulse = 5'h00;
    startup_active = 1'b0;
    sleep_active = 1'b0;
    last_slot = 3'h0;
  end
  // slots four cycles apart so each effect lands before the next slot
  always @(posedge core_clk) begin
    slot_pulse <= 5'h00;
    if (cnt != 0) begin
      cnt <= cnt + 1;
      if (cnt % 4 == 0 && cnt <= 20) begin
        slot_pulse[cnt / 4 - 1] <= 1'b1;
        last_slot <= 3'(cnt / 4);
      end
      if (cnt == 24) begin
        cnt <= 0;
        startup_active <= 1'b0;
        sleep_active <= 1'b0;
      end
    end else if (run_start || run_sleep) begin
      cnt <= 1;
      startup_active <= run_start;
      sleep_active <= run_sleep;
    end
  end
endmodule : lr4_seq_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  import lr4_pkg::*;
  typedef struct packed { logic [15:0] a, r, w, e; } lr4_reg_row_t;
  typedef struct packed { logic [2:0] on, slp, en_at, chg_at; } lr4_seq_row_t;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  lr4_word_t   reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        run_start = 1'b0;
  logic        run_sleep = 1'b0;
  logic        hw_enable_1 = 1'b0;
  logic        hw_enable_2 = 1'b0;
  logic        hw_control_1 = 1'b0;
  logic        hw_control_2 = 1'b0;
  logic        uv_error = 1'b0;
  lr4_word_t   reg_rdata, d;
  logic [4:0]  slot_pulse;
  logic        startup_active, sleep_active;
  logic [2:0]  last_slot, en_slot, chg_slot;
  logic        reg_enable, reg_low_power, reg_lp_variant, reg_pass_switch;
  logic        reg_discharge, device_reset_req, irq, en_q;
  lr4_vcode_t  reg_voltage_code, v_q;
  logic [15:0] rr_cnt;
  int          err_count = 0;
  int          checked = 0;
  lr4_reg_row_t regs [7] = '{'{16'h4071, 16'h0200, 16'hffff, 16'hdfc1},
    '{16'h4072, 16'h0000, 16'hffff, 16'he11f}, '{16'h4073, 16'h0100, 16'hffff, 16'he11f},
    '{16'h4070, 16'h0000, 16'hffff, 16'h0000}, '{16'h4074, 16'h0000, 16'hffff, 16'h0000},
    '{16'h4078, 16'h0000, 16'hffff, 16'h0000}, '{16'h4079, 16'h0000, 16'hffff, 16'h0001}};
  lr4_seq_row_t seqs [9] = '{'{3'h1, 3'h1, 3'h1, 3'h5}, '{3'h2, 3'h2, 3'h2, 3'h4},
    '{3'h3, 3'h3, 3'h3, 3'h3}, '{3'h4, 3'h4, 3'h4, 3'h2}, '{3'h5, 3'h5, 3'h5, 3'h1},
    '{3'h5, 3'h0, 3'h5, 3'h5}, '{3'h1, 3'h6, 3'h1, 3'h3}, '{3'h1, 3'h7, 3'h1, 3'h1},
    '{3'h0, 3'h1, 3'h0, 3'h0}};
  logic [1:0]  acts [4] = '{2'h0, 2'h3, 2'h2, 2'h1};

  always #2.5 core_clk = ~core_clk;

  lr4_ctrl lr4_ctrl_i (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .slot_pulse(slot_pulse), .startup_active(startup_active), .sleep_active(sleep_active),
    .hw_enable_1(hw_enable_1), .hw_enable_2(hw_enable_2), .hw_control_1(hw_control_1),
    .hw_control_2(hw_control_2), .uv_error(uv_error), .reg_enable(reg_enable),
    .reg_voltage_code(reg_voltage_code), .reg_low_power(reg_low_power),
    .reg_lp_variant(reg_lp_variant), .reg_pass_switch(reg_pass_switch),
    .reg_discharge(reg_discharge), .device_reset_req(device_reset_req), .irq(irq));
  lr4_seq_model lr4_seq_model_i (.core_clk(core_clk), .run_start(run_start),
    .run_sleep(run_sleep), .slot_pulse(slot_pulse), .startup_active(startup_active),
    .sleep_active(sleep_active), .last_slot(last_slot));

  // slot in which the output last moved, so slot timing is judged without cycle counting
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_slot <= 3'h0;
      chg_slot <= 3'h0;
      en_q <= 1'b0;
      v_q <= 5'h00;
      rr_cnt <= 16'h0000;
    end else begin
      en_q <= reg_enable;
      v_q <= reg_voltage_code;
      if (reg_enable && !en_q) en_slot <= last_slot;
      if (en_q && (!reg_enable || v_q != reg_voltage_code)) chg_slot <= last_slot;
      rr_cnt <= rr_cnt + 16'(device_reset_req);
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc
  task automatic wr(input logic [15:0] a, input lr4_word_t w);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, output lr4_word_t r);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 r = reg_rdata;
    @(posedge core_clk);
  endtask : rd
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic reset_dut();
    rst_b <= 1'b0;
    cyc(2);
    rst_b <= 1'b1;
    cyc(1);
  endtask : reset_dut
  task automatic run(input logic up);
    run_start <= up;
    run_sleep <= !up;
    @(posedge core_clk);
    run_start <= 1'b0;
    run_sleep <= 1'b0;
    cyc(30);
  endtask : run
  task automatic uv();
    uv_error <= 1'b1;
    cyc(8);
    uv_error <= 1'b0;
    cyc(4);
  endtask : uv
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  initial begin
    #100us;
    err_count++;
    summarize();
  end

  initial begin
    cyc(16);
    rst_b <= 1'b1;
    cyc(1);
    chk("reset discharge", reg_discharge, 1);
    chk("reset enable", reg_enable, 0);
    chk("reset low power", reg_low_power, 0);
    chk("reset lp variant", reg_lp_variant, 0);
    chk("reset switch", reg_pass_switch, 0);
    chk("reset request", device_reset_req, 0);
    chk("reset irq", irq, 0);
    foreach (regs[i]) begin
      rd(regs[i].a, d);
      chk("reset value", d, regs[i].r);
      wr(regs[i].a, regs[i].w);
      rd(regs[i].a, d);
      chk("readback", d, regs[i].e);
    end
    foreach (seqs[i]) begin
      reset_dut();
      wr(16'h4072, {seqs[i].on, 13'h000a});
      wr(16'h4073, {seqs[i].slp, 13'h011f});
      run(1'b1);
      chk("enable slot", en_slot, seqs[i].en_at);
      if (seqs[i].on != 3'h0) chk("on code", reg_voltage_code, 5'h0a);
      if (seqs[i].on != 3'h0) chk("on mode", reg_low_power, 0);
      run(1'b0);
      chk("sleep slot", chg_slot, seqs[i].chg_at);
      if (seqs[i].on != 3'h0 && seqs[i].slp inside {3'h0, 3'h6, 3'h7}) begin
        chk("sleep code", reg_voltage_code, 5'h1f);
        chk("sleep mode", reg_low_power, 1);
      end
      if (seqs[i].slp inside {[3'h1:3'h5]}) chk("off discharge", reg_discharge, 1);
    end
    reset_dut();
    wr(16'h4072, 16'h200a);
    wr(16'h4073, 16'h0115);
    run(1'b1);
    wr(16'h4071, 16'h0c01);
    hw_control_1 <= 1'b1;
    cyc(6);
    chk("hw code", reg_voltage_code, 5'h15);
    chk("hw low power", reg_low_power, 1);
    chk("lp variant", reg_lp_variant, 1);
    hw_control_1 <= 1'b0;
    hw_control_2 <= 1'b1;
    cyc(6);
    chk("source pick", reg_voltage_code, 5'h0a);
    wr(16'h4071, 16'h1b00);
    cyc(4);
    chk("hw follow mode", reg_low_power, 0);
    chk("hw on code", reg_voltage_code, 5'h0a);
    wr(16'h4071, 16'h0500);
    cyc(4);
    chk("source off enable", reg_enable, 1);
    chk("source off code", reg_voltage_code, 5'h0a);
    wr(16'h4071, 16'h1d41);
    cyc(4);
    chk("hw off", reg_enable, 0);
    chk("discharge", reg_discharge, 1);
    chk("switch", reg_pass_switch, 1);
    wr(16'h4071, 16'h1dc1);
    cyc(4);
    chk("float", reg_discharge, 0);
    hw_control_2 <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      reset_dut();
      wr(16'h4072, i ? 16'he00a : 16'hc00a);
      wr(16'h4073, 16'h2115);
      run(1'b1);
      chk("pin low", reg_enable, 0);
      if (i)
        hw_enable_2 <= 1'b1;
      else
        hw_enable_1 <= 1'b1;
      cyc(6);
      chk("pin high", reg_enable, 1);
      run(1'b0);
      chk("hw sleep code", reg_voltage_code, 5'h15);
      chk("hw sleep on", reg_enable, 1);
      hw_enable_1 <= 1'b0;
      hw_enable_2 <= 1'b0;
      cyc(1);
    end
    reset_dut();
    wr(16'h4072, 16'h200a);
    run(1'b1);
    foreach (acts[i]) begin
      wr(16'h4071, {acts[i], 14'h0200});
      uv();
      chk("irq", irq, 1);
      chk("uv enable", reg_enable, 16'(acts[i] != 2'h1));
      // pulse count is cumulative; only 10 requests, and it comes before 01
      chk("reset req", rr_cnt, 16'(acts[i] == 2'h2 || acts[i] == 2'h1));
      wr(16'h4078, 16'h0001);
      cyc(1);
      chk("irq clear", irq, 0);
    end
    wr(16'h4079, 16'h0001);
    uv();
    chk("masked irq", irq, 0);
    rd(16'h4078, d);
    chk("status", d, 16'h0001);
    summarize();
  end
endmodule : tb
